// file: rtl/sbmp_pkg.sv
package sbmp_pkg;

  localparam logic [11:0] SBMP_OFS_PAUSE   = 12'h04E;
  localparam logic [11:0] SBMP_OFS_RESUME  = 12'h04F;
  localparam logic [11:0] SBMP_OFS_LINES   = 12'h054;
  localparam logic [11:0] SBMP_OFS_MOTOR   = 12'h060;
  localparam logic [11:0] SBMP_OFS_STEP    = 12'h061;
  localparam logic [11:0] SBMP_OFS_CURRENT = 12'h062;
  localparam logic [11:0] SBMP_OFS_MEM     = 12'h063;
  localparam logic [11:0] SBMP_OFS_STATUS  = 12'h064;
  localparam logic [11:0] SBMP_OFS_FILL    = 12'h065;

  // Byte address is four times the index
  localparam int SBMP_ADDR_SHIFT = 2;

  localparam logic [7:0]  SBMP_PAUSE_RST   = 8'hFF;
  localparam logic [7:0]  SBMP_RESUME_RST  = 8'h00;
  localparam logic [2:0]  SBMP_LINES_RST   = 3'h0;
  localparam logic [13:0] SBMP_STEP_RST    = 14'h0100;
  localparam logic [2:0]  SBMP_KICK_RST    = 3'h0;
  localparam logic [4:0]  SBMP_HOLD_RST    = 5'h00;

  localparam int SBMP_KB_SHIFT     = 10;
  localparam logic [9:0] SBMP_KB_LOW = 10'h3FF;
  localparam int SBMP_FILL_W       = 19;

  localparam int SBMP_MCLK_HZ      = 250_000_000;
  localparam int SBMP_PIX_DIV      = 24;
  localparam int SBMP_USTEP_PER_FS = 4;

  // Motor control register fields
  localparam int SBMP_MC_CMD   = 0;
  localparam int SBMP_MC_FWD   = 2;
  localparam int SBMP_MC_MSTEP = 3;
  // Current register fields
  localparam int SBMP_CU_KICK  = 0;
  localparam int SBMP_CU_HOLD  = 8;
  // Memory register fields
  localparam int SBMP_ME_SIZE  = 0;
  localparam int SBMP_ME_600   = 2;

  localparam logic [18:0] SBMP_KB64  = 19'h10000;
  localparam logic [18:0] SBMP_KB128 = 19'h20000;
  localparam logic [18:0] SBMP_KB256 = 19'h40000;
  localparam logic [18:0] SBMP_COEF300 = 19'h04000;
  localparam logic [18:0] SBMP_COEF600 = 19'h08000;

  typedef enum logic [1:0] {
    SBMP_CMD_IDLE = 2'b00,
    SBMP_CMD_SCAN = 2'b01,
    SBMP_CMD_FEED = 2'b10,
    SBMP_CMD_RSV  = 2'b11
  } sbmp_cmd_t;

  // DAC current levels
  typedef enum logic [1:0] {
    SBMP_DAC_OFF  = 2'b00,
    SBMP_DAC_HOLD = 2'b01,
    SBMP_DAC_RUN  = 2'b10,
    SBMP_DAC_KICK = 2'b11
  } sbmp_dac_t;

  typedef enum logic [1:0] {
    SBMP_MS_IDLE = 2'b00,
    SBMP_MS_RUN  = 2'b01,
    SBMP_MS_HOLD = 2'b10,
    SBMP_MS_OFF  = 2'b11
  } sbmp_mstate_t;

  typedef struct packed {
    logic a;
    logic b;
    logic a_n;
    logic b_n;
  } sbmp_phase_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } sbmp_apb_req_t;

endpackage

// file: rtl/sbmp_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module sbmp_top
  import sbmp_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // APB slave
  input  wire sbmp_apb_req_t apb_i,
  output logic [31:0]        prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  // Pixel byte stream into memory and out to host
  input  wire logic          wr_byte_i,
  input  wire logic          rd_byte_i,
  // Line boundary from sensor timing
  input  wire logic          line_end_i,
  // Motor drive
  output sbmp_phase_t        phase_o,
  output sbmp_dac_t          dac_o,
  output logic               paused_o
);

  logic [7:0]             pause_level;
  logic [7:0]             resume_level;
  logic [2:0]             lines_after_halt;
  logic [3:0]             motor_ctl;
  logic [13:0]            microstep_interval;
  logic [2:0]             kick_steps;
  logic [4:0]             hold_steps;
  logic [2:0]             mem_cfg;
  logic [SBMP_FILL_W-1:0] fill;
  logic                   pause_req;
  logic                   motor_stop;
  logic [3:0]             lines_left;
  logic [4:0]             pix_cnt;
  logic                   pix_tick;
  logic [13:0]            ustep_cnt;
  logic                   ustep_tick;
  logic [1:0]             usub;
  logic [1:0]             fs_pos;
  logic [4:0]             cur_cnt;
  sbmp_mstate_t           mstate;
  sbmp_dac_t              dac_lvl;
  logic                   wr_en;
  logic                   rd_en;
  logic [9:0]             idx;
  logic [18:0]            capacity;
  logic [18:0]            mem_bytes;
  logic [SBMP_FILL_W-1:0] pause_fill;
  logic [SBMP_FILL_W-1:0] resume_fill;
  logic                   moving;
  logic                   run_cmd;

  assign idx   = apb_i.paddr[11:SBMP_ADDR_SHIFT];
  assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign rd_en = apb_i.psel && !apb_i.pwrite;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  // Register writes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pause_level        <= SBMP_PAUSE_RST;
      resume_level       <= SBMP_RESUME_RST;
      lines_after_halt   <= SBMP_LINES_RST;
      motor_ctl          <= 4'h0;
      microstep_interval <= SBMP_STEP_RST;
      kick_steps         <= SBMP_KICK_RST;
      hold_steps         <= SBMP_HOLD_RST;
      mem_cfg            <= 3'h0;
    end else if (wr_en) begin
      case (idx)
        SBMP_OFS_PAUSE[9:0]:   pause_level <= apb_i.pwdata[7:0];
        SBMP_OFS_RESUME[9:0]:  resume_level <= apb_i.pwdata[7:0];
        SBMP_OFS_LINES[9:0]:   lines_after_halt <= apb_i.pwdata[2:0];
        SBMP_OFS_MOTOR[9:0]:   motor_ctl <= apb_i.pwdata[3:0];
        SBMP_OFS_STEP[9:0]:    microstep_interval <= apb_i.pwdata[13:0];
        SBMP_OFS_CURRENT[9:0]: begin
          kick_steps <= apb_i.pwdata[SBMP_CU_KICK +: 3];
          hold_steps <= apb_i.pwdata[SBMP_CU_HOLD +: 5];
        end
        SBMP_OFS_MEM[9:0]:     mem_cfg <= apb_i.pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Memory size less coefficient area
  always_comb begin
    case (mem_cfg[SBMP_ME_SIZE +: 2])
      2'b00:   mem_bytes = SBMP_KB64;
      2'b01:   mem_bytes = SBMP_KB128;
      default: mem_bytes = SBMP_KB256;
    endcase
    capacity = mem_bytes - (mem_cfg[SBMP_ME_600] ? SBMP_COEF600 : SBMP_COEF300);
  end

  // Register reads, zero-wait
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en && !apb_i.penable) begin
      case (idx)
        SBMP_OFS_PAUSE[9:0]:   prdata_o <= {24'h0, pause_level};
        SBMP_OFS_RESUME[9:0]:  prdata_o <= {24'h0, resume_level};
        SBMP_OFS_LINES[9:0]:   prdata_o <= {29'h0, lines_after_halt};
        SBMP_OFS_MOTOR[9:0]:   prdata_o <= {28'h0, motor_ctl};
        SBMP_OFS_STEP[9:0]:    prdata_o <= {18'h0, microstep_interval};
        SBMP_OFS_CURRENT[9:0]: prdata_o <= {19'h0, hold_steps, 5'h0, kick_steps};
        SBMP_OFS_MEM[9:0]:     prdata_o <= {13'h0, capacity};
        SBMP_OFS_STATUS[9:0]:  prdata_o <= {24'h0, mstate, dac_lvl, fs_pos, motor_stop, pause_req};
        SBMP_OFS_FILL[9:0]:    prdata_o <= {13'h0, fill};
        default:               prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Buffer fill level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fill <= '0;
    end else if (wr_byte_i != rd_byte_i) begin
      fill <= wr_byte_i ? fill + 19'd1 : fill - 19'd1;
    end
  end

  assign pause_fill  = {1'b0, pause_level, 10'h000};
  assign resume_fill = {1'b0, resume_level, SBMP_KB_LOW};

  // Pause and resume handshake
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pause_req <= 1'b0;
    end else if (!pause_req && fill == pause_fill) begin
      pause_req <= 1'b1;
    end else if (pause_req && fill == resume_fill) begin
      pause_req <= 1'b0;
    end
  end

  // Motor stops once current line and extra lines are done
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      motor_stop <= 1'b0;
      lines_left <= 4'h0;
    end else if (!pause_req) begin
      motor_stop <= 1'b0;
      lines_left <= {1'b0, lines_after_halt} + 4'h1;
    end else if (line_end_i && lines_left != 4'h0) begin
      lines_left <= lines_left - 4'h1;
    end else if (lines_left == 4'h0) begin
      motor_stop <= 1'b1;
    end
  end
  assign paused_o = pause_req;

  // Pixel period divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pix_cnt <= 5'h00;
    end else if (pix_cnt == 5'(SBMP_PIX_DIV - 1)) begin
      pix_cnt <= 5'h00;
    end else begin
      pix_cnt <= pix_cnt + 5'h01;
    end
  end
  assign pix_tick = pix_cnt == 5'(SBMP_PIX_DIV - 1);

  assign run_cmd = motor_ctl[SBMP_MC_CMD +: 2] != SBMP_CMD_IDLE;
  assign moving  = run_cmd && !motor_stop;

  // Microstep interval counter, also paces the hold timeout
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ustep_cnt <= 14'h0000;
    end else if (!moving && mstate != SBMP_MS_HOLD) begin
      ustep_cnt <= 14'h0000;
    end else if (pix_tick) begin
      ustep_cnt <= (ustep_cnt + 14'h0001 >= microstep_interval) ? 14'h0000 : ustep_cnt + 14'h0001;
    end
  end
  assign ustep_tick = moving && pix_tick && (ustep_cnt + 14'h0001 >= microstep_interval);

  // Microstep and full step position
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      usub   <= 2'h0;
      fs_pos <= 2'h0;
    end else if (ustep_tick) begin
      usub <= usub + 2'h1;
      if (usub == 2'(SBMP_USTEP_PER_FS - 1)) begin
        fs_pos <= motor_ctl[SBMP_MC_FWD] ? fs_pos + 2'h1 : fs_pos - 2'h1;
      end
    end
  end

  // Current state machine
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mstate  <= SBMP_MS_IDLE;
      dac_lvl <= SBMP_DAC_OFF;
      cur_cnt <= 5'h00;
    end else if (!run_cmd) begin
      mstate  <= SBMP_MS_IDLE;
      dac_lvl <= SBMP_DAC_OFF;
    end else begin
      case (mstate)
        SBMP_MS_IDLE, SBMP_MS_OFF: begin
          if (moving) begin
            mstate  <= SBMP_MS_RUN;
            cur_cnt <= {2'h0, kick_steps};
            dac_lvl <= (kick_steps != 3'h0) ? SBMP_DAC_KICK : SBMP_DAC_RUN;
          end
        end
        SBMP_MS_RUN: begin
          if (!moving) begin
            mstate  <= (hold_steps != 5'h00) ? SBMP_MS_HOLD : SBMP_MS_OFF;
            dac_lvl <= (hold_steps != 5'h00) ? SBMP_DAC_HOLD : SBMP_DAC_OFF;
            cur_cnt <= hold_steps;
          end else if (ustep_tick && usub == 2'h3 && dac_lvl == SBMP_DAC_KICK) begin
            if (cur_cnt == 5'h01) begin
              dac_lvl <= SBMP_DAC_RUN;
            end
            cur_cnt <= cur_cnt - 5'h01;
          end
        end
        SBMP_MS_HOLD: begin
          if (moving) begin
            mstate  <= SBMP_MS_RUN;
            dac_lvl <= SBMP_DAC_RUN;
          end else if (pix_tick && (ustep_cnt + 14'h0001 >= microstep_interval)) begin
            if (cur_cnt <= 5'h01) begin
              mstate  <= SBMP_MS_OFF;
              dac_lvl <= SBMP_DAC_OFF;
            end
            cur_cnt <= cur_cnt - 5'h01;
          end
        end
        default: mstate <= SBMP_MS_IDLE;
      endcase
    end
  end

  // Square-wave quadrature phases
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_o <= '0;
    end else if (!run_cmd || mstate == SBMP_MS_OFF || mstate == SBMP_MS_IDLE) begin
      phase_o <= '0;
    end else begin
      phase_o.a   <= !fs_pos[1];
      phase_o.a_n <= fs_pos[1];
      phase_o.b   <= !(fs_pos[1] ^ fs_pos[0]);
      phase_o.b_n <= fs_pos[1] ^ fs_pos[0];
    end
  end
  assign dac_o = dac_lvl;

endmodule

// file: tb/sbmp_host_model.sv
`timescale 1ns/100ps
module sbmp_host_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Pace control
  input  wire logic en_i,
  input  wire logic slow_i,
  // Byte taken by host
  output logic      rd_byte_o
);
  logic [3:0] pace;
  // Drains only while asked; level sizing is the bench's job
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pace      <= 4'h0;
      rd_byte_o <= 1'b0;
    end else begin
      pace      <= pace + 4'h1;
      rd_byte_o <= en_i & (!slow_i | pace == 4'hF);
    end
  end
endmodule

// file: tb/sbmp_properties.sv
`timescale 1ns/100ps
module sbmp_props_chk
  import sbmp_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          resetn_i,
  input wire sbmp_apb_req_t apb_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic          wr_byte_i,
  input wire logic          rd_byte_i,
  input wire logic          line_end_i,
  input wire sbmp_phase_t   phase_o,
  input wire sbmp_dac_t     dac_o,
  input wire logic          paused_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [18:0] fill;
  logic [7:0]  pz;
  logic [7:0]  rs;
  logic [1:0]  cmd;
  logic [7:0]  gap;
  sbmp_phase_t ph_q;
  wire         wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  wire [9:0]   ix = apb_i.paddr[11:2];
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fill <= '0;
    end else begin
      fill <= fill + 19'(wr_byte_i) - 19'(rd_byte_i);
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pz  <= SBMP_PAUSE_RST;
      rs  <= SBMP_RESUME_RST;
      cmd <= 2'h0;
    end else if (wr) begin
      if (ix == SBMP_OFS_PAUSE[9:0]) pz <= apb_i.pwdata[7:0];
      if (ix == SBMP_OFS_RESUME[9:0]) rs <= apb_i.pwdata[7:0];
      if (ix == SBMP_OFS_MOTOR[9:0]) cmd <= apb_i.pwdata[1:0];
    end
  end
  // Cycles since the last full step; a start from rest does not count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph_q <= '0;
      gap  <= 8'h00;
    end else begin
      ph_q <= phase_o;
      if (phase_o != ph_q) begin
        gap <= (ph_q == '0) ? 8'hFF : 8'h00;
      end else begin
        gap <= (gap == 8'hFF) ? gap : gap + 8'h01;
      end
    end
  end
  sequence s_rd_acc;
    apb_i.psel && apb_i.penable && !apb_i.pwrite;
  endsequence
  sequence s_flip;
    $changed(phase_o) && $past(phase_o) != '0 && phase_o != '0;
  endsequence
  property p_ready;
    pready_o && !pslverr_o;
  endproperty
  property p_unmapped;
    s_rd_acc and ix < 10'h04E |-> prdata_o == 32'h0;
  endproperty
  property p_rise;
    $rose(paused_o) |-> $past(fill) == {$past(pz), 10'h000};
  endproperty
  property p_pause;
    !paused_o && fill == {pz, 10'h000} |=> paused_o;
  endproperty
  property p_resume;
    paused_o && fill == {rs, 10'h3FF} |=> !paused_o;
  endproperty
  property p_fall;
    $fell(paused_o) |-> $past(fill) == {$past(rs), 10'h3FF};
  endproperty
  property p_idle;
    cmd == 2'h0 [*2] |-> phase_o == '0;
  endproperty
  property p_winding;
    !(phase_o.a && phase_o.a_n) && !(phase_o.b && phase_o.b_n);
  endproperty
  property p_quad;
    s_flip |-> $countones(phase_o ^ $past(phase_o)) == 2;
  endproperty
  property p_gap;
    ph_q != '0 && phase_o != '0 && phase_o != ph_q |-> gap >= 8'd95;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rise: assert property (p_rise) else $error("pause at wrong fill");
  a_pause: assert property (p_pause) else $error("pause missed");
  a_resume: assert property (p_resume) else $error("resume missed");
  a_fall: assert property (p_fall) else $error("resume at wrong fill");
  a_idle: assert property (p_idle) else $error("phases on while idle");
  a_winding: assert property (p_winding) else $error("winding both ways");
  a_quad: assert property (p_quad) else $error("not one winding per step");
  a_gap: assert property (p_gap) else $error("full step too soon");
endmodule
bind sbmp_top sbmp_props_chk sbmp_props_chk_inst (.clk_i, .resetn_i, .apb_i, .prdata_o, .pready_o, .pslverr_o,
  .wr_byte_i, .rd_byte_i, .line_end_i, .phase_o, .dac_o, .paused_o);

// file: tb/scan_buffer_motor_pacer_bench.sv
`timescale 1ns/100ps
module scan_buffer_motor_pacer_bench
  import sbmp_pkg::*;
;
  logic          clk;
  logic          rstn;
  sbmp_apb_req_t req;
  logic [31:0]   prdata;
  logic          pready;
  logic          wr;
  logic          le;
  logic          en;
  logic          slow;
  logic          rd;
  sbmp_phase_t   ph;
  sbmp_dac_t     dac;
  logic          paused;
  logic [31:0]   exp_q[$];
  logic [31:0]   fill_m;
  logic [31:0]   seed;
  logic [31:0]   b;
  int            error_cnt;
  int            n_compared;
  int            k;
  sbmp_phase_t   p0;
  logic [11:0]   ri[5] = '{SBMP_OFS_PAUSE, SBMP_OFS_RESUME, SBMP_OFS_LINES, SBMP_OFS_STEP, SBMP_OFS_FILL};
  logic [31:0]   rv[5] = '{32'hFF, 32'h0, 32'h0, 32'h100, 32'h0};
  logic [18:0]   kb[3] = '{SBMP_KB64, SBMP_KB128, SBMP_KB256};
  sbmp_top sbmp_top_inst (.clk_i(clk), .resetn_i(rstn), .apb_i(req), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(), .wr_byte_i(wr), .rd_byte_i(rd), .line_end_i(le), .phase_o(ph), .dac_o(dac), .paused_o(paused));
  sbmp_host_model sbmp_host_model_inst (.clk_i(clk), .resetn_i(rstn), .en_i(en), .slow_i(slow), .rd_byte_o(rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic lim(input int n);
    if (k >= n) begin
      error_cnt++;
      $display("CHECK FAILED %0t: timeout", $time);
      test_done();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ix, input logic [31:0] d);
    @(posedge clk);
    req <= '{paddr: 12'(ix << SBMP_ADDR_SHIFT), psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
    lim(20);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] ix, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, ix, 32'h0);
  endtask
  // Read results come off the queue at the access edge
  always @(posedge clk) begin
    if (req.psel && req.penable && !req.pwrite && pready === 1'b1) chk(prdata, exp_q.pop_front());
    fill_m <= fill_m + wr - rd;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    seed = 32'hCC806BF2;
    {rstn, wr, le, en, slow} = '0;
    req = '0;
    fill_m = 0;
    error_cnt = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (ri[i]) rdr(ri[i], rv[i]);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    rdr(12'h010, 32'h0);
    for (int s = 0; s < 6; s++) begin
      apb(1'b1, SBMP_OFS_MEM, 32'((s / 3) * 4 + s % 3));
      rdr(SBMP_OFS_MEM, 32'(kb[s % 3] - ((s > 2) ? SBMP_COEF600 : SBMP_COEF300)));
    end
    apb(1'b1, SBMP_OFS_PAUSE, 32'h1);
    apb(1'b1, SBMP_OFS_STEP, 32'h1);
    apb(1'b1, SBMP_OFS_CURRENT, 32'h0102);
    apb(1'b1, SBMP_OFS_MOTOR, 32'h5);
    for (k = 0; k < 300 && ph === '0; k++) @(posedge clk);
    lim(300);
    chk(32'(dac), 32'(SBMP_DAC_KICK));
    p0 = ph;
    for (k = 0; k < 300 && ph === p0; k++) @(posedge clk);
    lim(300);
    p0 = ph;
    for (k = 0; k < 300 && ph === p0; k++) @(posedge clk);
    lim(300);
    chk(k, 96);
    chk(32'(dac), 32'(SBMP_DAC_RUN));
    chk(ph.a, p0.b);
    for (k = 0; k < 1024; k += b[0]) begin
      @(posedge clk);
      b = $random(seed);
      wr <= b[0];
    end
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
    chk(paused, 1'b0);
    @(negedge clk);
    chk(paused, 1'b1);
    rdr(SBMP_OFS_FILL, 32'd1024);
    le <= 1'b1;
    @(posedge clk);
    le <= 1'b0;
    for (k = 0; k < 300 && dac !== SBMP_DAC_HOLD; k++) @(posedge clk);
    lim(300);
    for (k = 0; k < 2000 && ph !== '0; k++) @(posedge clk);
    lim(2000);
    chk(32'(dac), 32'(SBMP_DAC_OFF));
    en <= 1'b1;
    for (k = 0; k < 4000 && paused === 1'b1; k++) begin
      b = $random(seed);
      wr <= b[0];
      @(posedge clk);
    end
    lim(4000);
    wr <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge clk);
    rdr(SBMP_OFS_FILL, fill_m);
    for (k = 0; k < 3000 && ph === '0; k++) @(posedge clk);
    lim(3000);
    en <= 1'b1;
    slow <= 1'b1;
    repeat (64) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    rdr(SBMP_OFS_FILL, fill_m);
    apb(1'b1, SBMP_OFS_MOTOR, 32'h2);
    repeat (3) @(posedge clk);
    p0 = ph;
    for (k = 0; k < 300 && ph === p0; k++) @(posedge clk);
    lim(300);
    chk(ph.b, p0.a);
    apb(1'b1, SBMP_OFS_MOTOR, 32'h0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(ph), 32'h0);
    @(posedge clk);
    test_done();
  end
endmodule
